// ===== device_option_and_watchdog_config_tb_top.sv
// self-checking bench of the option loader
`timescale 1ns/1ps
`default_nettype none
`include "dowc_cfg.svh"
module device_option_and_watchdog_config_tb_top;
   logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nv_valid = 1'b0;
   logic        sleep_mode = 1'b0, low_power_rc_oscillator_tick = 1'b0, frc_tick = 1'b0, otg_id_pin_i = 1'b0;
   logic        usb_vbus_on = 1'b1, port_id_out = 1'b1, otg_id_pin_o;
   logic [1:0]  dflt_pin_o, alt_pin_o;
   logic [1:0]  i2c_pull_low = 2'h1, pins = 2'h2;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, nv_rdata = 32'h0, rd;
   logic        pclk, pready, pslverr, nv_req, vbus_pin_o, vbus_pin_oe, otg_id_pin_oe, err;
   logic        usb_id_in, port_id_in, secondary_oscillator_high_power, wdt_enable, wdt_windowed, wdt_post_tick;
   logic [1:0]  nv_index, dflt_pin_oe, alt_pin_oe, i2c_line_in, wdt_window_size;
   logic [31:0] prdata;
   logic [31:0] mem [4];
   // watchdog setups {sleep, enable, clock, run scale, sleep scale} and tick gaps
   logic [13:0] cfg [7] = '{{2'h1, 2'h0, 5'h02, 5'h00}, {2'h1, 2'h1, 5'h00, 5'h00},
      {2'h1, 2'h2, 5'h01, 5'h00}, {2'h1, 2'h3, 5'h01, 5'h00}, {2'h3, 2'h0, 5'h00, 5'h01},
      {2'h0, 2'h0, 5'h00, 5'h00}, {2'h1, 2'h2, 5'h03, 5'h00}};
   int          gap [7] = '{4, 1, 6, 10, 10, 200, 24};
   int          miscompares = 0, n_tests = 0, ph = 0;
   dowc_loader uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nv_req(nv_req), .nv_index(nv_index), .nv_valid(nv_valid),
      .nv_rdata(nv_rdata), .usb_vbus_on(usb_vbus_on), .port_vbus_out(1'b0),
      .port_vbus_oe(1'b0), .vbus_pin_o(vbus_pin_o), .vbus_pin_oe(vbus_pin_oe),
      .otg_id_pin_i(otg_id_pin_i), .port_id_out(port_id_out), .port_id_oe(1'b1),
      .otg_id_pin_o(otg_id_pin_o), .otg_id_pin_oe(otg_id_pin_oe), .usb_id_in(usb_id_in),
      .port_id_in(port_id_in), .i2c_pull_low(i2c_pull_low), .dflt_pin_i(pins),
      .alt_pin_i(~pins), .dflt_pin_o(dflt_pin_o), .dflt_pin_oe(dflt_pin_oe),
      .alt_pin_o(alt_pin_o), .alt_pin_oe(alt_pin_oe), .i2c_line_in(i2c_line_in),
      .secondary_oscillator_high_power(secondary_oscillator_high_power), .sleep_mode(sleep_mode), .low_power_rc_oscillator_tick(low_power_rc_oscillator_tick),
      .frc_tick(frc_tick), .wdt_enable(wdt_enable), .wdt_windowed(wdt_windowed),
      .wdt_window_size(wdt_window_size), .wdt_post_tick(wdt_post_tick));
   // clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // oscillator ticks every third and fifth cycle
   always @(posedge pclk) begin
      ph <= ph + 1;
      frc_tick <= ph % 3 == 0;
      low_power_rc_oscillator_tick <= ph % 5 == 0;
   end
   // nonvolatile store answering each fetch after two idle cycles
   always @(posedge pclk) if (nv_req) begin
      repeat (2) @(posedge pclk);
      nv_valid <= 1'b1;
      nv_rdata <= mem[nv_index];
      @(posedge pclk);
      nv_valid <= 1'b0;
      nv_rdata <= ~nv_rdata;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         miscompares++;
         $display("mismatch at %0t: wait ran out", $time);
         test_done();
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      bound(n, 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // optionally start a reload, then poll status until loaded and idle
   task automatic load(input logic bank, input logic kick);
      int n;
      n = 0;
      if (kick) apb(1'b1, `DOWC_OFS_CTRL, {30'h0, 1'b1, bank});
      do begin
         apb(1'b0, `DOWC_OFS_STAT, 32'h0);
         n++;
      end while (rd[1:0] !== 2'h1 && n < 50);
      bound(n, 50);
      repeat (4) @(posedge pclk);
   endtask
   function automatic logic [31:0] wdw(input logic [13:0] c, input logic dis,
                                        input logic [1:0] sz);
      return {16'hFFFF, c[12:5], dis, sz, c[4:0]};
   endfunction
   task automatic pins_chk(input logic [31:0] o, input logic [31:0] w);
      chk({vbus_pin_o, vbus_pin_oe}, {2{o[15]}});
      chk({otg_id_pin_o, dflt_pin_o, alt_pin_o}, 5'h10);
      chk({otg_id_pin_oe, usb_id_in, port_id_in}, {!o[14], !o[14], 1'b0});
      chk({dflt_pin_oe, alt_pin_oe, i2c_line_in}, o[4] ? {4'h4, pins} : {4'h1, ~pins});
      chk(secondary_oscillator_high_power, !o[3]);
      chk(wdt_enable, w[15]);
      chk({wdt_windowed, wdt_window_size}, w[7] ? 3'h0 : {1'b1, w[6:5]});
      apb(1'b0, `DOWC_OFS_DEVOPT, 32'h0);
      chk(rd & ~`DOWC_DEVOPT_RSV, o & ~`DOWC_DEVOPT_RSV);
      apb(1'b0, `DOWC_OFS_WDT, 32'h0);
      chk(rd[15:0], w[15:0]);
   endtask
   // cycles between two watchdog ticks; 200 means none came
   task automatic gap_chk(input int exp);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (wdt_post_tick !== 1'b1 && n < 200);
      end
      // a tick that was due and never came ends the run
      if (exp < 200) bound(n, 200);
      chk(n, exp);
   endtask
   // main sequence
   initial begin
      mem[0] = {16'hA5C3, 2'h3, 9'h1FF, 2'h3, 3'h7};
      mem[1] = wdw({2'h1, 2'h0, 5'h02, 5'h00}, 1'b0, 2'h2);
      mem[2] = {16'h3C5A, 2'h0, 9'h1FE, 2'h0, 3'h7};
      mem[3] = wdw({2'h0, 2'h3, 5'h01, 5'h01}, 1'b1, 2'h0);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      load(1'b0, 1'b0);
      apb(1'b0, `DOWC_OFS_STAT, 32'h0);
      chk(rd[3:0], 4'h9);
      pins_chk(mem[0], mem[1]);
      apb(1'b1, `DOWC_OFS_DEVOPT, 32'h0);
      chk(err, 1'b1);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      load(1'b1, 1'b1);
      apb(1'b0, `DOWC_OFS_STAT, 32'h0);
      chk(rd[3:0], 4'h5);
      pins_chk(mem[2], mem[3]);
      for (int i = 0; i < 7; i++) begin
         mem[1] = wdw(cfg[i], 1'b1, 2'h0);
         sleep_mode <= cfg[i][13];
         load(1'b0, 1'b1);
         gap_chk(gap[i]);
      end
      test_done();
   end
endmodule
bind dowc_loader dowc_chk chk_i (.pclk(pclk), .presetn(presetn), .pwrite(pwrite),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata), .nv_req(nv_req),
   .nv_valid(nv_valid), .nv_index(nv_index), .nv_rdata(nv_rdata),
   .usb_vbus_on(usb_vbus_on), .port_vbus_out(port_vbus_out), .vbus_pin_o(vbus_pin_o),
   .port_id_oe(port_id_oe), .otg_id_pin_oe(otg_id_pin_oe), .i2c_pull_low(i2c_pull_low),
   .dflt_pin_oe(dflt_pin_oe), .secondary_oscillator_high_power(secondary_oscillator_high_power), .wdt_enable(wdt_enable),
   .wdt_windowed(wdt_windowed));
`default_nettype wire

// ===== dowc_cfg.svh
// offsets, field positions and reset values of the option loader
`ifndef DOWC_CFG_SVH
`define DOWC_CFG_SVH
// ---------------------------------------
// register byte offsets
// ---------------------------------------
`define DOWC_OFS_DEVOPT 8'h00
`define DOWC_OFS_WDT    8'h04
`define DOWC_OFS_CTRL   8'h08
`define DOWC_OFS_STAT   8'h0C
// ---------------------------------------
// field positions and values
// ---------------------------------------
`define DOWC_CTRL_ALT    0
`define DOWC_CTRL_RELOAD 1
`define DOWC_WORD_RST    32'hFFFFFFFF
`define DOWC_DEVOPT_RSV  32'h00003FE7
`define DOWC_WDT_RSV     32'hFFFF0000
`define DOWC_PS_MAX      5'h14
`define DOWC_IDX_DEVOPT  1'h0
`define DOWC_IDX_WDT     1'h1
`endif

// ===== dowc_chk.sv
// property checker of the option loader ports
`timescale 1ns/1ps
`default_nettype none
module dowc_chk (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // word fetch
   input wire logic        nv_req,
   input wire logic        nv_valid,
   input wire logic [1:0]  nv_index,
   input wire logic [31:0] nv_rdata,
   // pins
   input wire logic        usb_vbus_on,
   input wire logic        port_vbus_out,
   input wire logic        vbus_pin_o,
   input wire logic        port_id_oe,
   input wire logic        otg_id_pin_oe,
   input wire logic [1:0]  i2c_pull_low,
   input wire logic [1:0]  dflt_pin_oe,
   // oscillator and watchdog
   input wire logic        secondary_oscillator_high_power,
   input wire logic        wdt_enable,
   input wire logic        wdt_windowed
);
   logic [31:0] dev_q, wdt_q;
   logic        busy_q;
   logic [1:0]  idle_q;
   wire         settled = !busy_q && idle_q == 2'h3;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // shadow words as fetched; outputs are judged only once a load has settled, except pslverr in a_ro_write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_q  <= 32'hFFFFFFFF;
         wdt_q  <= 32'hFFFFFFFF;
         busy_q <= 1'b1;
         idle_q <= 2'h0;
      end else begin
         if (nv_valid && busy_q && !nv_index[0]) dev_q <= nv_rdata;
         if (nv_valid && busy_q && nv_index[0]) wdt_q <= nv_rdata;
         busy_q <= nv_req || (busy_q && !(nv_valid && nv_index[0]));
         idle_q <= busy_q ? 2'h0 : idle_q + {1'b0, idle_q != 2'h3};
      end
   end
   property p_id_read;
      pready && !pwrite && paddr == 8'h00 && settled |-> prdata[31:16] == dev_q[31:16];
   endproperty
   a_id_read: assert property (p_id_read) else $error("user id read back wrong");
   property p_ro_write;
      pready && pwrite && paddr == 8'h00 |-> pslverr;
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("write to option word accepted");
   property p_vbus;
      settled |-> vbus_pin_o == $past(dev_q[15] ? usb_vbus_on : port_vbus_out);
   endproperty
   a_vbus: assert property (p_vbus) else $error("bus power pin from wrong owner");
   property p_id_pin;
      settled |-> otg_id_pin_oe == $past(port_id_oe && !dev_q[14]);
   endproperty
   a_id_pin: assert property (p_id_pin) else $error("id pin enable from wrong owner");
   property p_i2c;
      settled |-> dflt_pin_oe == (dev_q[4] ? $past(i2c_pull_low) : 2'h0);
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c drive on wrong pin pair");
   property p_secondary_oscillator;
      settled |-> secondary_oscillator_high_power == !dev_q[3];
   endproperty
   a_secondary_oscillator: assert property (p_secondary_oscillator) else $error("oscillator power mode wrong");
   property p_wen;
      settled |-> wdt_enable == wdt_q[15];
   endproperty
   a_wen: assert property (p_wen) else $error("watchdog enable wrong");
   property p_win;
      settled |-> wdt_windowed != wdt_q[7];
   endproperty
   a_win: assert property (p_win) else $error("windowed mode wrong");
endmodule
`default_nettype wire

// ===== dowc_loader.sv
// loader and decoder of the device-options and watchdog words
// Functional notes
// [RL1] upper 16 bits of options word: user id, read back unchanged
// [RL2] bus-power pin owner 1: USB drives enable pin; 0: port logic
// [RL3] ID pin owner 1: USB controls ID pin; 0: port logic
// [RL4] programmer writes ones into options bits 13-5 and 2-0
// [RL5] alternate I2C bit 1: default pins; 0: alternate pin pair
// [RL6] oscillator power bit 1: normal power; 0: high power
// [RL7] watchdog enable bit enables the watchdog
// [RL8] clock select 11 low-power RC, 10 fast RC, 00 system clock
// [RL9] run postscale divides by 2^code, codes 10100 up give maximum
// [RL10] window disable 1: non-windowed; 0: windowed operation
// [RL11] programmer writes ones into watchdog word bits 31-16
// [RL12] sleep postscale sets sleep ratio, same mapping as run
// [RL13] window size field applies only while windowed
`timescale 1ns/1ps
`default_nettype none
`include "dowc_cfg.svh"
module dowc_loader
   import dowc_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // nonvolatile word fetch
   output logic             nv_req,
   output logic [1:0]       nv_index,
   input  wire logic        nv_valid,
   input  wire logic [31:0] nv_rdata,
   // bus-power enable pin
   input  wire logic        usb_vbus_on,
   input  wire logic        port_vbus_out,
   input  wire logic        port_vbus_oe,
   output logic             vbus_pin_o,
   output logic             vbus_pin_oe,
   // otg id pin
   input  wire logic        otg_id_pin_i,
   input  wire logic        port_id_out,
   input  wire logic        port_id_oe,
   output logic             otg_id_pin_o,
   output logic             otg_id_pin_oe,
   output logic             usb_id_in,
   output logic             port_id_in,
   // i2c lines, bit 0 data, bit 1 clock
   input  wire logic [1:0]  i2c_pull_low,
   input  wire logic [1:0]  dflt_pin_i,
   input  wire logic [1:0]  alt_pin_i,
   output logic [1:0]       dflt_pin_o,
   output logic [1:0]       dflt_pin_oe,
   output logic [1:0]       alt_pin_o,
   output logic [1:0]       alt_pin_oe,
   output logic [1:0]       i2c_line_in,
   // oscillator and watchdog
   output logic             secondary_oscillator_high_power,
   input  wire logic        sleep_mode,
   input  wire logic        low_power_rc_oscillator_tick,
   input  wire logic        frc_tick,
   output logic             wdt_enable,
   output logic             wdt_windowed,
   output logic [1:0]       wdt_window_size,
   output logic             wdt_post_tick
);

   // ---------------------------------------
   // loader state
   // ---------------------------------------
   typedef enum logic [1:0] {
      LD_IDLE,
      LD_REQ,
      LD_WAIT
   } dowc_ld_t;

   dowc_ld_t     ld_q;
   dowc_ld_t     ld_d;
   logic         word_q;
   logic         loaded_q;
   logic         alt_q;
   logic         reload_q;
   dowc_devopt_t dev_q;
   dowc_wdt_t    wdt_q;
   logic         nv_req_q;

   // ---------------------------------------
   // apb decode
   // ---------------------------------------
   wire logic setup_ph = psel & ~penable;
   wire logic access_ph = psel & penable & pready;
   wire logic hit_dev = paddr == `DOWC_OFS_DEVOPT;
   wire logic hit_wdt = paddr == `DOWC_OFS_WDT;
   wire logic hit_ctl = paddr == `DOWC_OFS_CTRL;
   wire logic hit_sts = paddr == `DOWC_OFS_STAT;
   wire logic hit_any = hit_dev | hit_wdt | hit_ctl | hit_sts;
   wire logic bad_req = ~hit_any | (pwrite & ~hit_ctl);
   wire logic ctl_wr = access_ph & pwrite & hit_ctl & ~pslverr;
   wire logic busy = ld_q != LD_IDLE;

   // reserved bits all ones in both words
   wire logic rsv_ok =
      ((dev_q & `DOWC_DEVOPT_RSV) == `DOWC_DEVOPT_RSV) & // RL4
      ((wdt_q & `DOWC_WDT_RSV) == `DOWC_WDT_RSV);        // RL11

   wire logic [31:0] stat_word =
      {28'h0000000, rsv_ok, alt_q, busy, loaded_q};
   wire logic [31:0] ctl_word = {31'h00000000, alt_q};

   // read data mux
   wire logic [31:0] rd_mux =
      hit_dev ? dev_q :                                  // RL1
      hit_wdt ? wdt_q :
      hit_ctl ? ctl_word :
      hit_sts ? stat_word : 32'h00000000;

   // answer set up in the setup cycle, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata  <= pwrite ? 32'h00000000 : rd_mux;
         pready  <= 1'b1;
         pslverr <= bad_req;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ---------------------------------------
   // control register
   // ---------------------------------------
   wire logic go = ld_q == LD_IDLE;

   // bank select and reload request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_q    <= 1'b0;
         reload_q <= 1'b1;
      end else if (ctl_wr) begin
         alt_q    <= pwdata[`DOWC_CTRL_ALT];
         reload_q <= pwdata[`DOWC_CTRL_RELOAD] | (reload_q & ~go);
      end else if (go) begin
         reload_q <= 1'b0;
      end
   end

   // ---------------------------------------
   // word fetch sequence
   // ---------------------------------------
   always_comb begin
      ld_d = ld_q;
      case (ld_q)
         LD_IDLE: begin
            if (reload_q)
               ld_d = LD_REQ;
         end
         LD_REQ: begin
            ld_d = LD_WAIT;
         end
         LD_WAIT: begin
            if (nv_valid)
               ld_d = (word_q == `DOWC_IDX_WDT) ? LD_IDLE : LD_REQ;
         end
         default: begin
            ld_d = LD_IDLE;
         end
      endcase
   end

   wire logic take = (ld_q == LD_WAIT) & nv_valid;

   // state, word pointer and request strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_q     <= LD_IDLE;
         word_q   <= `DOWC_IDX_DEVOPT;
         nv_req_q <= 1'b0;
         loaded_q <= 1'b0;
      end else begin
         ld_q     <= ld_d;
         nv_req_q <= ld_d == LD_REQ && ld_q != LD_REQ;
         if (go && reload_q)
            word_q <= `DOWC_IDX_DEVOPT;
         else if (take)
            word_q <= `DOWC_IDX_WDT;
         if (take && word_q == `DOWC_IDX_WDT)
            loaded_q <= 1'b1;
      end
   end

   // fetched words, erased value until loaded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_q <= `DOWC_WORD_RST;
         wdt_q <= `DOWC_WORD_RST;
      end else if (take) begin
         if (word_q == `DOWC_IDX_WDT)
            wdt_q <= nv_rdata;
         else
            dev_q <= nv_rdata;
      end
   end

   assign nv_req   = nv_req_q;
   assign nv_index = {alt_q, word_q};

   // ---------------------------------------
   // pin input synchronisers
   // ---------------------------------------
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 5'h1F;
         pin_s2_q <= 5'h1F;
      end else begin
         pin_s1_q <= {otg_id_pin_i, alt_pin_i, dflt_pin_i};
         pin_s2_q <= pin_s1_q;
      end
   end

   wire logic [1:0] dflt_s = pin_s2_q[1:0];
   wire logic [1:0] alt_s  = pin_s2_q[3:2];
   wire logic       id_s   = pin_s2_q[4];

   // ---------------------------------------
   // usb pin ownership
   // ---------------------------------------
   wire logic vb_own = dev_q.bus_power_pin_owner;
   wire logic id_own = dev_q.id_pin_owner;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vbus_pin_o    <= 1'b0;
         vbus_pin_oe   <= 1'b0;
         otg_id_pin_o  <= 1'b0;
         otg_id_pin_oe <= 1'b0;
         usb_id_in     <= 1'b1;
         port_id_in    <= 1'b1;
      end else begin
         vbus_pin_o    <= vb_own ? usb_vbus_on : port_vbus_out; // RL2
         vbus_pin_oe   <= vb_own | port_vbus_oe;               // RL2
         otg_id_pin_o  <= port_id_out;
         otg_id_pin_oe <= ~id_own & port_id_oe;                // RL3
         usb_id_in     <= id_own ? id_s : 1'b1;                // RL3
         port_id_in    <= id_s;
      end
   end

   // ---------------------------------------
   // i2c pin routing, open drain
   // ---------------------------------------
   wire logic use_dflt = dev_q.alternate_i2c_location;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_line
         // route each line to one pin pair
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dflt_pin_o[g]  <= 1'b0;
               alt_pin_o[g]   <= 1'b0;
               dflt_pin_oe[g] <= 1'b0;
               alt_pin_oe[g]  <= 1'b0;
               i2c_line_in[g] <= 1'b1;
            end else begin
               dflt_pin_o[g]  <= 1'b0;
               alt_pin_o[g]   <= 1'b0;
               dflt_pin_oe[g] <= use_dflt & i2c_pull_low[g];  // RL5
               alt_pin_oe[g]  <= ~use_dflt & i2c_pull_low[g]; // RL5
               i2c_line_in[g] <= use_dflt ? dflt_s[g] : alt_s[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------
   // oscillator and watchdog settings
   // ---------------------------------------
   wire logic wdt_on = wdt_q.watchdog_enable_bit;
   wire logic win_on = ~wdt_q.window_disable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         secondary_oscillator_high_power <= 1'b0;
         wdt_enable      <= 1'b0;
         wdt_windowed    <= 1'b0;
         wdt_window_size <= 2'h0;
      end else begin
         secondary_oscillator_high_power <= ~dev_q.secondary_osc_power; // RL6
         wdt_enable      <= loaded_q & wdt_on;          // RL7
         wdt_windowed    <= win_on;                     // RL10
         wdt_window_size <= win_on ?                    // RL13
                            wdt_q.window_size_field : 2'h0;
      end
   end

   // ---------------------------------------
   // watchdog clock select and postscaler
   // ---------------------------------------
   logic wdt_tick;

   always_comb begin
      wdt_tick = 1'b1;
      if (sleep_mode)
         wdt_tick = low_power_rc_oscillator_tick;
      else
         case (wdt_q.run_clock_select)          // RL8
            DOWC_CLK_LOW:  wdt_tick = low_power_rc_oscillator_tick;
            DOWC_CLK_FAST: wdt_tick = frc_tick;
            default:       wdt_tick = 1'b1;
         endcase
   end

   // run or sleep code, saturated at the largest ratio
   wire logic [4:0] ps_code = sleep_mode ?
      wdt_q.sleep_postscale : wdt_q.run_postscale;  // RL12
   wire logic [4:0] ps_exp = (ps_code > `DOWC_PS_MAX) ?
      `DOWC_PS_MAX : ps_code;                       // RL9
   wire logic [19:0] ps_lim = ~(20'hFFFFF << ps_exp); // RL9

   logic [19:0] ps_cnt_q;

   // one output pulse every 2^exp selected ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_cnt_q      <= 20'h00000;
         wdt_post_tick <= 1'b0;
      end else if (!(loaded_q && wdt_on)) begin
         ps_cnt_q      <= 20'h00000;
         wdt_post_tick <= 1'b0;
      end else if (wdt_tick) begin
         wdt_post_tick <= ps_cnt_q >= ps_lim;
         ps_cnt_q      <= (ps_cnt_q >= ps_lim) ?
                          20'h00000 : ps_cnt_q + 20'h00001;
      end else begin
         wdt_post_tick <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ===== dowc_pkg.sv
// types of the option loader
package dowc_pkg;
   // ---------------------------------------
   // decoded words
   // ---------------------------------------
   typedef enum logic [1:0] {
      DOWC_CLK_SYS  = 2'h0,
      DOWC_CLK_RSV  = 2'h1,
      DOWC_CLK_FAST = 2'h2,
      DOWC_CLK_LOW  = 2'h3
   } dowc_clk_t;
   typedef struct packed {
      logic [15:0] user_identifier_value;
      logic        bus_power_pin_owner;
      logic        id_pin_owner;
      logic [8:0]  rsv_hi;
      logic        alternate_i2c_location;
      logic        secondary_osc_power;
      logic [2:0]  rsv_lo;
   } dowc_devopt_t;
   typedef struct packed {
      logic [15:0] rsv;
      logic        watchdog_enable_bit;
      dowc_clk_t   run_clock_select;
      logic [4:0]  run_postscale;
      logic        window_disable;
      logic [1:0]  window_size_field;
      logic [4:0]  sleep_postscale;
   } dowc_wdt_t;
endpackage
